// >>> inc/fpei_pkg.sv
/*
 flash program/erase interface: register map, field positions, key codes,
 timing counts and shared types.
 assumes a 200 MHz system clock and byte-wide register access.
*/
package fpei_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] KEY_ADDR = 8'h84;
	localparam logic [7:0] CTL_ADDR = 8'h85;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'h86;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h87;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] KEY_RESET = 8'h00;
	// ==========================================================
	// control fields
	localparam int PROG_EN_BIT = 0;
	localparam int ERASE_EN_BIT = 1;
	localparam int TRIGGER_BIT = 3;
	localparam int ERROR_BIT = 4;
	// ==========================================================
	// key bytes
	localparam logic [7:0] KEY_FIRST = 8'h5a;
	localparam logic [7:0] KEY_SECOND = 8'h1f;
	// ==========================================================
	// timing
	localparam int CLK_MHZ = 200;
	localparam int ERASE_TIME_MS = 120;
	localparam int PROG_TIME_US = 100;
	localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	// ==========================================================
	// interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam int IRQ_FREEZE_BIT = 2;
	// ==========================================================
	// types
	typedef enum logic [1:0] {
		KEY_LOCKED = 2'b00,
		KEY_HALF = 2'b01,
		KEY_FROZEN = 2'b10,
		KEY_OPEN = 2'b11
	} fpei_key_t;
	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_ERASE = 2'b01,
		OP_PROG = 2'b10
	} fpei_op_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fpei_regreq_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		logic wr;
	} fpei_xmem_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		logic erase;
		logic prog;
	} fpei_flash_t;
endpackage

// >>> verilog/fpei_flash_if.sv
/*
 flash program/erase interface: key lock, control register, target
 capture, operation timer and interrupt status.
 assumes a single-cycle register port and a flash array that reports
 a failed operation on flashFail when the timer ends.
*/
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - control bit 4 reads the error of the last operation or refused trigger, read-only
// - writing 1 to control bit 3 launches the operation; 0 does nothing
// - erase needs program and erase enables; otherwise a byte program
// - program enable clear blocks both program and erase
// - key opens only after first key byte then second key byte
// - wrong key order or value freezes the key until system reset
// - any control write while open relocks the key
// - key read gives state in bits 1:0: 00 locked,01 half,11 open,10 frozen
// - operation length set by internal timer; completion relocks key
module fpei_flash_if #(
	parameter int ERASE_CNT = fpei_pkg::ERASE_CYCLES,
	parameter int PROG_CNT = fpei_pkg::PROG_CYCLES
)(
	input wire logic clk_sys,
	input wire logic reset,
	input wire fpei_pkg::fpei_regreq_t regReq,
	output logic [7:0] regRdata,
	input wire fpei_pkg::fpei_xmem_t xmemIn,
	output logic xmemRamWr,
	output fpei_pkg::fpei_flash_t flashCmd,
	input wire logic flashFail,
	output logic flashBusy,
	output logic irq
);
	// ==========================================================
	// state
	typedef struct packed {
		fpei_pkg::fpei_key_t key;
		logic progEn;
		logic eraseEn;
		logic opErr;
		fpei_pkg::fpei_op_t op;
		logic [31:0] cnt;
		logic [15:0] tgtAddr;
		logic [7:0] tgtData;
		logic tgtValid;
		fpei_pkg::fpei_flash_t cmd;
		logic [2:0] irqStat;
		logic [2:0] irqMask;
		logic [7:0] rdata;
	} fpei_state_t;

	fpei_state_t st_r;
	fpei_state_t st_nxt;

	function automatic logic [7:0] ctlView(input fpei_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[fpei_pkg::PROG_EN_BIT] = s.progEn;
		v[fpei_pkg::ERASE_EN_BIT] = s.eraseEn;
		v[fpei_pkg::ERROR_BIT] = s.opErr;
		return v;
	endfunction

	logic keyWr;
	logic ctlWr;
	logic armed;
	logic opEnd;
	logic [2:0] evt;

	assign keyWr = regReq.wr && regReq.addr == fpei_pkg::KEY_ADDR;
	assign ctlWr = regReq.wr && regReq.addr == fpei_pkg::CTL_ADDR;
	assign armed = st_r.key == fpei_pkg::KEY_OPEN && st_r.progEn;
	assign opEnd = st_r.op != fpei_pkg::OP_IDLE && st_r.cnt == 32'h0;

	// ==========================================================
	// next state
	always_comb
	begin
		st_nxt = st_r;
		evt = 3'h0;
		st_nxt.cmd.erase = 1'b0;
		st_nxt.cmd.prog = 1'b0;
		// key sequence
		if (keyWr && st_r.op == fpei_pkg::OP_IDLE)
		begin
			unique case (st_r.key)
				fpei_pkg::KEY_LOCKED:
				begin
					if (regReq.wdata == fpei_pkg::KEY_FIRST)
						st_nxt.key = fpei_pkg::KEY_HALF;
					else
						st_nxt.key = fpei_pkg::KEY_FROZEN;
				end
				fpei_pkg::KEY_HALF:
				begin
					if (regReq.wdata == fpei_pkg::KEY_SECOND)
						st_nxt.key = fpei_pkg::KEY_OPEN;
					else
						st_nxt.key = fpei_pkg::KEY_FROZEN;
				end
				// a key write while already open counts as a bad sequence
				fpei_pkg::KEY_OPEN: st_nxt.key = fpei_pkg::KEY_FROZEN;
				fpei_pkg::KEY_FROZEN: st_nxt.key = fpei_pkg::KEY_FROZEN;
			endcase
		end
		if (st_nxt.key == fpei_pkg::KEY_FROZEN &&
			st_r.key != fpei_pkg::KEY_FROZEN)
			evt[fpei_pkg::IRQ_FREEZE_BIT] = 1'b1;
		// target capture
		if (xmemIn.wr && armed && st_r.op == fpei_pkg::OP_IDLE)
		begin
			st_nxt.tgtAddr = xmemIn.addr;
			st_nxt.tgtData = xmemIn.data;
			st_nxt.tgtValid = 1'b1;
		end
		// control writes; ignored while an operation runs
		if (ctlWr && st_r.op == fpei_pkg::OP_IDLE)
		begin
			st_nxt.progEn = regReq.wdata[fpei_pkg::PROG_EN_BIT];
			st_nxt.eraseEn = regReq.wdata[fpei_pkg::ERASE_EN_BIT];
			if (st_r.key == fpei_pkg::KEY_OPEN)
			begin
				st_nxt.key = fpei_pkg::KEY_LOCKED;
				// launch uses enables as armed before this write
				if (regReq.wdata[fpei_pkg::TRIGGER_BIT] && st_r.progEn &&
					st_r.tgtValid)
				begin
					st_nxt.cmd.addr = st_r.tgtAddr;
					st_nxt.cmd.data = st_r.tgtData;
					st_nxt.opErr = 1'b0;
					st_nxt.tgtValid = 1'b0;
					if (st_r.eraseEn)
					begin
						st_nxt.op = fpei_pkg::OP_ERASE;
						st_nxt.cmd.erase = 1'b1;
						st_nxt.cnt = ERASE_CNT - 1;
					end
					else
					begin
						st_nxt.op = fpei_pkg::OP_PROG;
						st_nxt.cmd.prog = 1'b1;
						st_nxt.cnt = PROG_CNT - 1;
					end
				end
			end
			// trigger without a valid armed state is an error
			if (regReq.wdata[fpei_pkg::TRIGGER_BIT] &&
				!(st_r.key == fpei_pkg::KEY_OPEN && st_r.progEn &&
				st_r.tgtValid))
			begin
				st_nxt.opErr = 1'b1;
				evt[fpei_pkg::IRQ_ERR_BIT] = 1'b1;
			end
		end
		// operation timer
		if (st_r.op != fpei_pkg::OP_IDLE)
		begin
			if (opEnd)
			begin
				st_nxt.op = fpei_pkg::OP_IDLE;
				st_nxt.opErr = flashFail;
				if (st_r.key != fpei_pkg::KEY_FROZEN)
					st_nxt.key = fpei_pkg::KEY_LOCKED;
				evt[fpei_pkg::IRQ_DONE_BIT] = 1'b1;
				evt[fpei_pkg::IRQ_ERR_BIT] = flashFail;
			end
			else
				st_nxt.cnt = st_r.cnt - 32'h1;
		end
		// interrupt status: write one clears, set wins
		if (regReq.wr && regReq.addr == fpei_pkg::IRQ_STAT_ADDR)
			st_nxt.irqStat = st_r.irqStat & ~regReq.wdata[2:0];
		if (regReq.wr && regReq.addr == fpei_pkg::IRQ_MASK_ADDR)
			st_nxt.irqMask = regReq.wdata[2:0];
		st_nxt.irqStat = st_nxt.irqStat | evt;
		// read data, one cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (regReq.rd)
		begin
			unique case (regReq.addr)
				fpei_pkg::KEY_ADDR: st_nxt.rdata = {6'h0, st_r.key};
				fpei_pkg::CTL_ADDR: st_nxt.rdata = ctlView(st_r);
				fpei_pkg::IRQ_STAT_ADDR: st_nxt.rdata = {5'h0, st_r.irqStat};
				fpei_pkg::IRQ_MASK_ADDR: st_nxt.rdata = {5'h0, st_r.irqMask};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			st_r <= '0;
			st_r.key <= fpei_pkg::KEY_LOCKED;
			st_r.op <= fpei_pkg::OP_IDLE;
			{st_r.progEn, st_r.eraseEn} <= fpei_pkg::CTL_RESET[1:0];
		end
		else
			st_r <= st_nxt;
	end

	// ==========================================================
	// outputs
	assign regRdata = st_r.rdata;
	assign flashCmd = st_r.cmd;
	assign flashBusy = st_r.op != fpei_pkg::OP_IDLE;
	assign xmemRamWr = xmemIn.wr && !(armed && st_r.op ==
		fpei_pkg::OP_IDLE);
	assign irq = |(st_r.irqStat & st_r.irqMask);
endmodule

// >>> dv/fpei_flash_model.sv
/*
 flash array model: reports the outcome of each operation.
 assumes failReq is set by the bench before the trigger.
*/
`timescale 1ns/1ps
module fpei_flash_model (
	input wire logic clk_sys,
	input wire fpei_pkg::fpei_flash_t flashCmd,
	input wire logic failReq,
	output logic flashFail
);
	// ====
	// the result is latched at launch and held, as the array does
	logic fail_r = 1'b0;
	always_ff @(posedge clk_sys)
		if (flashCmd.erase || flashCmd.prog)
			fail_r <= failReq;
	assign flashFail = fail_r;
endmodule

// >>> dv/fpei_flash_if_sva.sv
/*
 port checker for the flash interface.
 assumes it is bound into fpei_flash_if.
*/
`timescale 1ns/1ps
module fpei_flash_if_sva #(
	parameter int ERASE_CNT = 20,
	parameter int PROG_CNT = 10
)(
	input wire logic clk_sys,
	input wire logic reset,
	input wire fpei_pkg::fpei_regreq_t regReq,
	input wire logic [7:0] regRdata,
	input wire fpei_pkg::fpei_xmem_t xmemIn,
	input wire logic xmemRamWr,
	input wire fpei_pkg::fpei_flash_t flashCmd,
	input wire logic flashFail,
	input wire logic flashBusy,
	input wire logic irq
);
	// ====
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	logic go;
	logic ers_r;
	int cnt_r = 0;
	assign go = flashCmd.erase | flashCmd.prog;
	// counts busy cycles since launch
	always_ff @(posedge clk_sys)
	begin
		if (go)
			ers_r <= flashCmd.erase;
		cnt_r <= go ? 1 : cnt_r + int'(flashBusy);
	end
	// ====
	chk_rd_answer:
	assert property (regRdata != 8'h00 |-> $past(regReq.rd))
		else $error("data without read");
	chk_ram_pass:
	assert property (xmemRamWr |-> xmemIn.wr)
		else $error("ram write without cpu write");
	chk_launch_cause:
	assert property (go |-> $past(regReq.wr && regReq.addr == 8'h85
		&& regReq.wdata[3]))
		else $error("launch without trigger");
	chk_launch_one:
	assert property (!(flashCmd.erase && flashCmd.prog))
		else $error("erase and program together");
	chk_launch_pulse:
	assert property (go |=> !go)
		else $error("launch longer than a cycle");
	chk_launch_busy:
	assert property (go |-> flashBusy && !$past(flashBusy))
		else $error("launch not starting busy");
	chk_busy_cause:
	assert property ($rose(flashBusy) |-> go)
		else $error("busy without launch");
	chk_op_length:
	assert property ($fell(flashBusy) |->
		cnt_r == (ers_r ? ERASE_CNT : PROG_CNT))
		else $error("wrong operation length");
	cover property (flashCmd.erase);
	cover property (flashCmd.prog);
	cover property (irq);
endmodule
bind fpei_flash_if fpei_flash_if_sva #(
	.ERASE_CNT(ERASE_CNT),
	.PROG_CNT(PROG_CNT)
) u_sva (
	.clk_sys(clk_sys),
	.reset(reset),
	.regReq(regReq),
	.regRdata(regRdata),
	.xmemIn(xmemIn),
	.xmemRamWr(xmemRamWr),
	.flashCmd(flashCmd),
	.flashFail(flashFail),
	.flashBusy(flashBusy),
	.irq(irq)
);

// >>> dv/tb_flash_program_erase_interface.sv
/*
 bench for the flash interface: register tasks and sequences.
 assumes the flash model in fpei_flash_model.
*/
`timescale 1ns/1ps
module tb_flash_program_erase_interface;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic failReq = 1'b0;
	fpei_pkg::fpei_regreq_t req = '0;
	fpei_pkg::fpei_xmem_t xm = '0;
	fpei_pkg::fpei_flash_t cmd;
	logic [7:0] rdat;
	logic ramWr, fail, busy, irq;
	int fail_count = 0;
	int checks_done = 0;
	always #2.5 clk_sys = ~clk_sys;
	// short counts keep the run brief
	fpei_flash_if #(.ERASE_CNT(20), .PROG_CNT(10)) dut (.clk_sys(clk_sys),
		.reset(reset), .regReq(req), .regRdata(rdat), .xmemIn(xm),
		.xmemRamWr(ramWr), .flashCmd(cmd), .flashFail(fail),
		.flashBusy(busy), .irq(irq));
	fpei_flash_model fm (.clk_sys(clk_sys), .flashCmd(cmd),
		.failReq(failReq), .flashFail(fail));
	// ====
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic ck(input logic [7:0] g, x);
		checks_done++;
		if (g !== x)
		begin
			fail_count++;
			$display("unexpected at %0t: %h not %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, m, e);
		@(posedge clk_sys);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 ck(rdat & m, e);
	endtask
	task automatic xw(input logic [15:0] a, input logic e, k);
		@(posedge clk_sys);
		xm <= '{a, a[7:0], 1'b1};
		#1 if (k) ck({7'h0, ramWr}, {7'h0, e});
		@(posedge clk_sys);
		xm.wr <= 1'b0;
	endtask
	task automatic op(input logic [7:0] c, t, input logic [15:0] a,
		input logic [1:0] e);
		wr(8'h85, c);
		wr(8'h84, 8'h5a);
		wr(8'h84, 8'h1f);
		xw(a, 1'b0, c[0]);
		wr(8'h85, t);
		#1 ck({6'h0, cmd.erase, cmd.prog}, {6'h0, e});
		if (e != 2'b00) ck(cmd.data, a[7:0]);
		if (e != 2'b00) ck(cmd.addr[15:8], a[15:8]);
		if (e != 2'b00) ck(cmd.addr[7:0], a[7:0]);
		rd(8'h84, 8'h03, 8'h00);
	endtask
	task automatic wt;
		int i;
		for (i = 0; i < 99 && busy !== 1'b0; i++)
			@(posedge clk_sys);
		ck({7'h0, busy}, 8'h00);
		if (busy !== 1'b0) stop_test;
	endtask
	// ====
	initial
	begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd(8'h84, 8'hff, 8'h00);
		rd(8'h85, 8'hff, 8'h00);
		rd(8'h80, 8'hff, 8'h00);
		wr(8'h87, 8'h03);
		wr(8'h84, 8'h5a);
		rd(8'h84, 8'h03, 8'h01);
		wr(8'h84, 8'h1f);
		rd(8'h84, 8'h03, 8'h03);
		wr(8'h85, 8'h01);
		rd(8'h84, 8'h03, 8'h00);
		xw(16'h0100, 1'b1, 1'b1);
		op(8'h01, 8'h00, 16'h03f1, 2'b00);
		op(8'h01, 8'h08, 16'h03f0, 2'b01);
		wt;
		rd(8'h86, 8'hff, 8'h01);
		ck({7'h0, irq}, 8'h01);
		rd(8'h85, 8'h10, 8'h00);
		wr(8'h86, 8'h01);
		rd(8'h86, 8'hff, 8'h00);
		ck({7'h0, irq}, 8'h00);
		failReq <= 1'b1;
		op(8'h03, 8'h08, 16'h0340, 2'b10);
		wt;
		rd(8'h85, 8'h10, 8'h10);
		rd(8'h86, 8'h03, 8'h03);
		failReq <= 1'b0;
		wr(8'h86, 8'h03);
		op(8'h02, 8'h08, 16'h0350, 2'b00);
		rd(8'h85, 8'h10, 8'h10);
		wr(8'h86, 8'h07);
		wr(8'h84, 8'h1f);
		rd(8'h84, 8'h03, 8'h02);
		wr(8'h84, 8'h5a);
		wr(8'h84, 8'h1f);
		rd(8'h84, 8'h03, 8'h02);
		ck({7'h0, irq}, 8'h00);
		wr(8'h87, 8'h07);
		rd(8'h86, 8'h04, 8'h04);
		ck({7'h0, irq}, 8'h01);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd(8'h84, 8'h03, 8'h00);
		stop_test;
	end
endmodule
